// file: common/can_mbox_pkg.sv
// Shared constants, types and carriers for the CAN message-object mailbox.
// Assumes one CPU-clock domain; the CAN engine sits on the same clock.
package can_mbox_pkg;
  // Mailbox geometry
  localparam int NUM_OBJ = 15;
  localparam int DATA_BYTES = 8;
  localparam int BYTES_PER_OBJ = 20;
  localparam int REG_TOTAL = 321;
  localparam int SFR_TOTAL = 34;
  localparam int OBJ_W = 4;
  localparam int IDX_W = 3;
  localparam int TIMER_W = 16;

  // Field positions in the page, control and status windows
  localparam int PAGE_OBJ_LSB = 4;
  localparam int CFG_LSB = 6;
  localparam int STAT_TXOK = 6;
  localparam int STAT_RXOK = 5;

  // Reset and limit values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [15:0] TIMER_MAX = 16'hffff;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;

  // Object configuration field
  typedef enum logic [1:0] {
    CFG_DIS = 2'b00,
    CFG_TX = 2'b01,
    CFG_RX = 2'b10,
    CFG_BUF = 2'b11
  } obj_cfg_t;

  // Window register selected by the CPU access
  typedef enum logic [2:0] {
    SEL_PAGE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_STAT = 3'b010,
    SEL_DATA = 3'b011,
    SEL_STMP_LO = 3'b100,
    SEL_STMP_HI = 3'b101,
    SEL_EN_LO = 3'b110,
    SEL_EN_HI = 3'b111
  } sfr_sel_t;

  // Frame handed over by the CAN engine after filtering
  typedef struct packed {
    logic [NUM_OBJ-1:0] hit;
    logic buf_match;
    logic [8*DATA_BYTES-1:0] data;
  } rx_frame_t;
endpackage : can_mbox_pkg

// file: hdl/can_mailbox_paging_buffer.sv
// Paged message-object mailbox with receive buffer and stamp timer.
// Assumes CPU strobes and CAN engine pulses are on sys_clk_i already.
//
// Contract
// - Fifteen objects reached through one page register
// - Object registers and enable summary reached via the window; interrupt summary and buffer-full flag are not
// - Page selects object for control/status window access
// - Data window pointer auto-increments over eight bytes
// - Each object owns private storage, no overlap
// - Config codes: disabled, transmit, receive, buffer
// - Non-disabled config write sets enable summary bit
// - Completion clears the object's enable summary bit unless a config write to it lands in that cycle
// - Lower object number wins transmit and store
// - Any object set may form the buffer
// - Individual receivers stay outside buffer storage
// - Unmasked buffer filter accepts every frame
// - Buffer frame goes to lowest free member
// - All members occupied sets buffer-full flag, interrupt
// - Full buffer stores nothing, overwrites no status
// - Enabled timer counts; stamps captured at completion
// - Timer wraps to zero, interrupt when enabled
// - Object interrupt sets its summary bit
`timescale 1ns/10ps
module can_mailbox_paging_buffer
  import can_mbox_pkg::*;
(
  // Clock, reset, clock enable
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // CPU window access
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire sfr_sel_t sfr_sel_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Controller settings
  input wire logic ctrl_enable_i,
  input wire logic timer_wrap_irq_enable_i,
  input wire logic buf_irq_enable_i,
  input wire logic buf_accept_all_i,
  input wire logic buffer_full_clr_i,
  input wire logic [NUM_OBJ-1:0] obj_irq_enable_i,
  // CAN engine side
  input wire logic tx_done_i,
  input wire logic rx_valid_i,
  input wire rx_frame_t rx_frame_i,
  output logic tx_pending_o,
  output logic [OBJ_W-1:0] tx_obj_o,
  output logic [8*DATA_BYTES-1:0] tx_data_o,
  output logic rx_stored_o,
  output logic [OBJ_W-1:0] rx_obj_o,
  // Summaries, flags, interrupts
  output logic [NUM_OBJ-1:0] object_enable_summary_o,
  output logic [NUM_OBJ-1:0] object_interrupt_summary_o,
  output logic buffer_full_flag_o,
  output logic buffer_full_irq_o,
  output logic timer_wrap_irq_o,
  output logic [TIMER_W-1:0] stamp_timer_o
);

  // Lowest set bit of a vector
  function automatic logic [OBJ_W-1:0] lowest(
    input logic [NUM_OBJ-1:0] v
  );
    logic [OBJ_W-1:0] r;
    r = '0;
    for (int k = NUM_OBJ - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = OBJ_W'(k);
      end
    end
    return r;
  endfunction : lowest

  // One-hot vector of an object number
  function automatic logic [NUM_OBJ-1:0] onehot(
    input logic [OBJ_W-1:0] n
  );
    return NUM_OBJ'(1) << n;
  endfunction : onehot

  // Page register and per-object state
  logic [OBJ_W-1:0] page_obj;
  logic [IDX_W-1:0] page_idx;
  obj_cfg_t cfg [NUM_OBJ];
  logic [7:0] stat [NUM_OBJ];
  logic [TIMER_W-1:0] stamp [NUM_OBJ];
  logic [7:0] mem [NUM_OBJ][DATA_BYTES];
  logic [NUM_OBJ-1:0] en;
  logic [NUM_OBJ-1:0] object_interrupt_summary;
  logic [TIMER_W-1:0] timer;
  logic buf_full;

  // Window decode
  wire sel_ok = page_obj < OBJ_W'(NUM_OBJ);
  wire [OBJ_W-1:0] obj_s = sel_ok ? page_obj : '0;
  wire wr_page = ce_i & sfr_wr_i & (sfr_sel_i == SEL_PAGE);
  wire wr_ctrl = ce_i & sfr_wr_i & (sfr_sel_i == SEL_CTRL) & sel_ok;
  wire wr_stat = ce_i & sfr_wr_i & (sfr_sel_i == SEL_STAT) & sel_ok;
  wire wr_data = ce_i & sfr_wr_i & (sfr_sel_i == SEL_DATA) & sel_ok;
  wire acc_data = ce_i & (sfr_wr_i | sfr_rd_i) & (sfr_sel_i == SEL_DATA);
  wire [IDX_W-1:0] next_idx = IDX_W'(page_idx + 3'h1);

  // Candidate sets for transmit, receive and buffer
  logic [NUM_OBJ-1:0] tx_cand;
  logic [NUM_OBJ-1:0] rx_ind;
  logic [NUM_OBJ-1:0] buf_mem;
  logic [NUM_OBJ-1:0] buf_free;
  genvar g;
  generate
    for (g = 0; g < NUM_OBJ; g++) begin : g_cand
      assign tx_cand[g] = en[g] & (cfg[g] == CFG_TX);
      assign rx_ind[g] = en[g] & (cfg[g] == CFG_RX);
      assign buf_mem[g] = cfg[g] == CFG_BUF;
      assign buf_free[g] = en[g] & buf_mem[g];
    end
  endgenerate

  // Receive selection and buffer occupancy
  wire buf_acc = rx_frame_i.buf_match | buf_accept_all_i;
  wire [NUM_OBJ-1:0] rx_cand =
    (rx_frame_i.hit & rx_ind) | ({NUM_OBJ{buf_acc}} & buf_free);
  wire store = ce_i & rx_valid_i & (|rx_cand);
  wire [OBJ_W-1:0] store_obj = lowest(rx_cand);
  wire [NUM_OBJ-1:0] store_vec = store ? onehot(store_obj) : '0;
  wire tx_go = ce_i & tx_done_i & tx_pending_o;
  wire [NUM_OBJ-1:0] tx_vec = tx_go ? onehot(tx_obj_o) : '0;
  wire [NUM_OBJ-1:0] done_vec = store_vec | tx_vec;
  wire [OBJ_W-1:0] tx_sel = lowest(tx_cand & ~tx_vec);
  wire full_set = |(store_vec & buf_free) &
    ~|(buf_free & ~store_vec);
  wire next_buf_full = full_set | (buf_full & ~buffer_full_clr_i);

  // Read data selection
  wire [7:0] rd_ctrl = sel_ok ? {cfg[obj_s], 6'h00} : 8'h00;
  wire [7:0] rd_stat = sel_ok ? stat[obj_s] : 8'h00;
  wire [7:0] rd_data = sel_ok ? mem[obj_s][page_idx] : 8'h00;
  wire [7:0] rd_stlo = sel_ok ? stamp[obj_s][7:0] : 8'h00;
  wire [7:0] rd_sthi = sel_ok ? stamp[obj_s][15:8] : 8'h00;
  wire [7:0] rd_mux =
    (sfr_sel_i == SEL_PAGE) ? {page_obj, 1'b0, page_idx} :
    (sfr_sel_i == SEL_CTRL) ? rd_ctrl :
    (sfr_sel_i == SEL_STAT) ? rd_stat :
    (sfr_sel_i == SEL_DATA) ? rd_data :
    (sfr_sel_i == SEL_STMP_LO) ? rd_stlo :
    (sfr_sel_i == SEL_STMP_HI) ? rd_sthi :
    (sfr_sel_i == SEL_EN_LO) ? en[7:0] :
    {1'b0, en[14:8]};

  // Page register and auto-incrementing data pointer
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      page_obj <= PAGE_RST[7:PAGE_OBJ_LSB];
      page_idx <= PAGE_RST[IDX_W-1:0];
    end else if (wr_page) begin
      page_obj <= sfr_wdata_i[7:PAGE_OBJ_LSB];
      page_idx <= sfr_wdata_i[IDX_W-1:0];
    end else if (acc_data) begin
      page_idx <= next_idx;
    end
  end

  // Registered read data
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (ce_i & sfr_rd_i) begin
      sfr_rdata_o <= rd_mux;
    end
  end

  // Per-object config, status, stamp and private data bytes
  generate
    for (g = 0; g < NUM_OBJ; g++) begin : g_obj
      wire mine = page_obj == OBJ_W'(g);
      wire st_wr = wr_stat & mine;
      wire [7:0] ok_bits = {1'b0, tx_vec[g], store_vec[g], 5'h00};
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cfg[g] <= CFG_DIS;
          en[g] <= 1'b0;
        end else if (wr_ctrl & mine) begin
          cfg[g] <= obj_cfg_t'(sfr_wdata_i[CFG_LSB+:2]);
          en[g] <= sfr_wdata_i[CFG_LSB+:2] != CFG_DIS;
        end else if (done_vec[g]) begin
          en[g] <= 1'b0;
        end
      end
      // Status: hardware set wins over a CPU write
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stat[g] <= STAT_RST;
        end else if (ce_i) begin
          stat[g] <= (st_wr ? sfr_wdata_i : stat[g]) | ok_bits;
        end
      end
      // Interrupt summary: set wins over clear by status write
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          object_interrupt_summary[g] <= 1'b0;
        end else if (done_vec[g] & obj_irq_enable_i[g]) begin
          object_interrupt_summary[g] <= 1'b1;
        end else if (st_wr & ~sfr_wdata_i[STAT_TXOK] &
                     ~sfr_wdata_i[STAT_RXOK]) begin
          object_interrupt_summary[g] <= 1'b0;
        end
      end
      // Stamp capture at completion
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stamp[g] <= TIMER_RST;
        end else if (done_vec[g]) begin
          stamp[g] <= timer;
        end
      end
      // Data bytes owned by this object alone
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          for (int b = 0; b < DATA_BYTES; b++) begin
            mem[g][b] <= 8'h00;
          end
        end else if (store_vec[g]) begin
          for (int b = 0; b < DATA_BYTES; b++) begin
            mem[g][b] <= rx_frame_i.data[8*b+:8];
          end
        end else if (wr_data & mine) begin
          mem[g][page_idx] <= sfr_wdata_i;
        end
      end
    end
  endgenerate

  // Summaries to the outside
  assign object_enable_summary_o = en;
  assign object_interrupt_summary_o = object_interrupt_summary;
  assign buffer_full_flag_o = buf_full;
  assign stamp_timer_o = timer;

  // Transmit request towards the CAN engine
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_pending_o <= 1'b0;
      tx_obj_o <= '0;
      tx_data_o <= '0;
    end else if (ce_i) begin
      tx_pending_o <= |(tx_cand & ~tx_vec);
      tx_obj_o <= tx_sel;
      for (int b = 0; b < DATA_BYTES; b++) begin
        tx_data_o[8*b+:8] <= mem[tx_sel][b];
      end
    end
  end

  // Receive store report
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_stored_o <= 1'b0;
      rx_obj_o <= '0;
    end else if (ce_i) begin
      rx_stored_o <= store;
      rx_obj_o <= store ? store_obj : rx_obj_o;
    end
  end

  // Buffer-full flag: set wins over the clear
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buf_full <= 1'b0;
      buffer_full_irq_o <= 1'b0;
    end else if (ce_i) begin
      buf_full <= next_buf_full;
      buffer_full_irq_o <= next_buf_full & buf_irq_enable_i;
    end
  end

  // Free-running stamp timer and wrap interrupt pulse
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer <= TIMER_RST;
      timer_wrap_irq_o <= 1'b0;
    end else if (ce_i) begin
      timer <= ctrl_enable_i ? TIMER_W'(timer + 16'h1) : TIMER_RST;
      timer_wrap_irq_o <= ctrl_enable_i & (timer == TIMER_MAX) &
        timer_wrap_irq_enable_i;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_ptr_advance: assert property (
    acc_data && !wr_page |=> page_idx == $past(next_idx))
    else $error("data pointer did not advance");
  a_ptr_wrap: assert property (
    acc_data && !wr_page && page_idx == IDX_LAST |=> page_idx == 3'h0)
    else $error("data pointer did not wrap to zero");
  a_cfg_enables: assert property (
    wr_ctrl && sfr_wdata_i[CFG_LSB+:2] != CFG_DIS
    |=> en[$past(page_obj)])
    else $error("config write left object disabled");
  a_done_clears: assert property (
    store && !(wr_ctrl && page_obj == store_obj) |=> !en[$past(store_obj)])
    else $error("completed object still enabled");
  a_tx_lowest: assert property (
    ce_i && |(tx_cand & ~tx_vec) |=>
    tx_pending_o && tx_obj_o == lowest($past(tx_cand & ~tx_vec)))
    else $error("transmit object is not the lowest");
  a_store_stamp: assert property (
    store |=> stamp[$past(store_obj)] == $past(timer)
    ##0 rx_stored_o && rx_obj_o == $past(store_obj))
    else $error("stamp or store report wrong");
  a_full_sets: assert property (
    ce_i && full_set |=> buffer_full_flag_o [*1] ##0
    (buffer_full_irq_o == $past(buf_irq_enable_i)))
    else $error("buffer-full flag not raised");
  a_full_blocks: assert property (
    ce_i && rx_valid_i && buf_free == '0 &&
    (rx_frame_i.hit & rx_ind) == '0 |=> !rx_stored_o)
    else $error("frame stored while buffer full");
  a_timer_wrap: assert property (
    ce_i && ctrl_enable_i && timer == TIMER_MAX && timer_wrap_irq_enable_i
    |=> timer_wrap_irq_o && timer == TIMER_RST)
    else $error("timer wrap missing");
  a_sit_sets: assert property (
    ce_i && |(done_vec & obj_irq_enable_i) |=>
    (object_interrupt_summary & $past(done_vec & obj_irq_enable_i)) ==
    $past(done_vec & obj_irq_enable_i))
    else $error("interrupt summary bit not set");

  c_buf_full: cover property (ce_i && full_set);
  c_tx_done: cover property (tx_go);
  c_ptr_wrap: cover property (acc_data && page_idx == IDX_LAST);
  c_wrap_irq: cover property (timer_wrap_irq_o);

endmodule : can_mailbox_paging_buffer

// file: tb/can_engine_model.sv
// Behavioural CAN engine facing the mailbox.
// Assumes the bench calls send_frame and drives on the falling edge.
`timescale 1ns/10ps
module can_engine_model
  import can_mbox_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Mailbox side
  input wire logic tx_go_i,
  input wire logic tx_pending_i,
  output logic tx_done_o,
  output logic rx_valid_o,
  output rx_frame_t rx_frame_o
);
  // Finish a pending transmit slowly, then let the next one settle
  initial begin
    tx_done_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
    forever begin
      @(negedge sys_clk_i);
      if (rstn_i && tx_go_i && tx_pending_i) begin
        repeat (2) @(negedge sys_clk_i);
        tx_done_o = 1'b1;
        @(negedge sys_clk_i);
        tx_done_o = 1'b0;
        repeat (3) @(negedge sys_clk_i);
      end
    end
  end

  // One filtered frame; stale lines never repeat the last one
  task automatic send_frame(input rx_frame_t f);
    @(negedge sys_clk_i);
    rx_frame_o = f;
    rx_valid_o = 1'b1;
    @(negedge sys_clk_i);
    rx_valid_o = 1'b0;
    rx_frame_o = ~f;
  endtask : send_frame
endmodule : can_engine_model

// file: tb/can_mailbox_paging_buffer_tb.sv
// Self-checking bench for the paged mailbox.
// Assumes the engine model stands in for the CAN side.
`timescale 1ns/10ps
module can_mailbox_paging_buffer_tb;
  import can_mbox_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  sfr_sel_t sfr_sel_i = SEL_PAGE;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic ctrl_enable_i = 1'b0;
  logic buf_accept_all_i = 1'b0;
  logic buffer_full_clr_i = 1'b0;
  logic ce_i = 1'b1;
  logic timer_wrap_irq_enable_i = 1'b0;
  logic buf_irq_enable_i = 1'b1;
  logic timer_wrap_irq_o;
  logic [OBJ_W-1:0] tx_obj_o;
  logic [8*DATA_BYTES-1:0] tx_data_o;
  logic tx_go = 1'b0;
  logic tx_done_i, rx_valid_i, tx_pending_o, rx_stored_o;
  logic buffer_full_flag_o, buffer_full_irq_o;
  rx_frame_t rx_frame_i;
  logic [OBJ_W-1:0] rx_obj_o;
  logic [NUM_OBJ-1:0] en_sum, irq_sum;
  logic [TIMER_W-1:0] stamp_timer_o;
  int num_errors = 0;
  int check_count = 0;
  logic [7:0] rv, s2;

  always #4 sys_clk_i = ~sys_clk_i;

  can_mailbox_paging_buffer i_dut (
    .sys_clk_i, .rstn_i, .ce_i, .sfr_wr_i, .sfr_rd_i, .sfr_sel_i,
    .sfr_wdata_i, .sfr_rdata_o, .ctrl_enable_i,
    .timer_wrap_irq_enable_i, .buf_irq_enable_i,
    .buf_accept_all_i, .buffer_full_clr_i, .obj_irq_enable_i('1),
    .tx_done_i, .rx_valid_i, .rx_frame_i, .tx_pending_o, .tx_obj_o,
    .tx_data_o, .rx_stored_o, .rx_obj_o,
    .object_enable_summary_o(en_sum), .object_interrupt_summary_o(irq_sum),
    .buffer_full_flag_o, .buffer_full_irq_o, .timer_wrap_irq_o,
    .stamp_timer_o);

  can_engine_model i_eng (
    .sys_clk_i, .rstn_i, .tx_go_i(tx_go), .tx_pending_i(tx_pending_o),
    .tx_done_o(tx_done_i), .rx_valid_o(rx_valid_i), .rx_frame_o(rx_frame_i));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input sfr_sel_t s, input logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_sel_i = s;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge sys_clk_i);
    sfr_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input sfr_sel_t s);
    @(negedge sys_clk_i);
    sfr_sel_i = s;
    sfr_rd_i = 1'b1;
    @(negedge sys_clk_i);
    sfr_rd_i = 1'b0;
    rv = sfr_rdata_o;
  endtask : rd

  // Bounded wait for an object's enable bit to drop
  task automatic wait_clear(input int obj);
    int n;
    n = 0;
    while (en_sum[obj] !== 1'b0 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 100) begin
      check(64'h1, 64'h0);
      tally_and_finish();
    end
  endtask : wait_clear

  function automatic rx_frame_t frm(input logic [14:0] h,
                                    input logic [63:0] d);
    return {h, 1'b0, d};
  endfunction : frm

  // Pointer walk, wrap and private storage
  task automatic t_page();
    wr(SEL_PAGE, 8'h30);
    for (int i = 0; i < 8; i++) wr(SEL_DATA, 8'h10 + i[7:0]);
    rd(SEL_PAGE);
    check(rv, 8'h30);
    wr(SEL_PAGE, 8'h40);
    wr(SEL_DATA, 8'h5a);
    wr(SEL_PAGE, 8'h30);
    for (int i = 0; i < 8; i++) begin
      rd(SEL_DATA);
      check(rv, 8'h10 + i[7:0]);
    end
    $display("test page done");
  endtask : t_page

  // Every configuration code and its summary bit
  task automatic t_cfg();
    wr(SEL_PAGE, 8'h60);
    for (int c = 3; c >= 0; c--) begin
      wr(SEL_CTRL, {c[1:0], 6'h00});
      check(en_sum[6], c != 0);
      rd(SEL_CTRL);
      check(rv, {c[1:0], 6'h00});
    end
    $display("test config done");
  endtask : t_cfg

  // Timer held at zero until enabled
  task automatic t_timer();
    check(stamp_timer_o, 16'h0000);
    ctrl_enable_i = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    check(stamp_timer_o, 16'h000a);
    ce_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    check(stamp_timer_o, 16'h000a);
    ce_i = 1'b1;
    $display("test timer done");
  endtask : t_timer

  // Two transmitters: lower number goes first
  task automatic t_tx();
    wr(SEL_PAGE, 8'h50);
    wr(SEL_CTRL, 8'h40);
    wr(SEL_PAGE, 8'h20);
    wr(SEL_DATA, 8'ha5);
    wr(SEL_CTRL, 8'h40);
    @(negedge sys_clk_i);
    check(tx_obj_o, 4'h2);
    check(tx_data_o, 64'ha5);
    tx_go = 1'b1;
    wait_clear(2);
    check(en_sum[5], 1'b1);
    check(tx_obj_o, 4'h5);
    check(tx_data_o, 64'h0);
    wait_clear(5);
    tx_go = 1'b0;
    check(en_sum[2], 1'b0);
    check(irq_sum[5], 1'b1);
    rd(SEL_STAT);
    check(rv & 8'h40, 8'h40);
    rd(SEL_STMP_LO);
    s2 = rv;
    wr(SEL_PAGE, 8'h50);
    rd(SEL_STMP_LO);
    check(rv > s2, 1'b1);
    $display("test transmit done");
  endtask : t_tx

  // Buffer fill, full blocking, release
  task automatic t_buf();
    wr(SEL_PAGE, 8'h30);
    wr(SEL_CTRL, 8'hc0);
    wr(SEL_PAGE, 8'h70);
    wr(SEL_CTRL, 8'hc0);
    wr(SEL_PAGE, 8'h10);
    wr(SEL_CTRL, 8'h80);
    buf_accept_all_i = 1'b1;
    i_eng.send_frame(frm(15'h0, 64'h11));
    check({rx_stored_o, rx_obj_o}, 5'h13);
    i_eng.send_frame(frm(15'h0, 64'h22));
    check({rx_stored_o, rx_obj_o}, 5'h17);
    check(buffer_full_flag_o, 1'b1);
    @(negedge sys_clk_i);
    check(buffer_full_irq_o, 1'b1);
    buf_irq_enable_i = 1'b0;
    @(negedge sys_clk_i);
    check(buffer_full_irq_o, 1'b0);
    check(buffer_full_flag_o, 1'b1);
    buf_irq_enable_i = 1'b1;
    i_eng.send_frame(frm(15'h0, 64'h33));
    check({rx_stored_o, rx_obj_o}, 5'h07);
    buf_accept_all_i = 1'b0;
    i_eng.send_frame(frm(15'h2, 64'h44));
    check({rx_stored_o, rx_obj_o}, 5'h11);
    rd(SEL_DATA);
    check(rv, 8'h44);
    wr(SEL_PAGE, 8'h70);
    rd(SEL_DATA);
    check(rv, 8'h22);
    buffer_full_clr_i = 1'b1;
    @(negedge sys_clk_i);
    buffer_full_clr_i = 1'b0;
    check(buffer_full_flag_o, 1'b0);
    wr(SEL_PAGE, 8'h30);
    wr(SEL_CTRL, 8'hc0);
    buf_accept_all_i = 1'b1;
    i_eng.send_frame(frm(15'h0, 64'h55));
    check({rx_stored_o, rx_obj_o}, 5'h13);
    $display("test buffer done");
  endtask : t_buf

  // Timer roll-over raises the wrap pulse once
  task automatic t_wrap();
    int n;
    n = 0;
    timer_wrap_irq_enable_i = 1'b1;
    while (stamp_timer_o !== TIMER_MAX && n < 70000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 70000) begin
      check(64'h1, 64'h0);
      tally_and_finish();
    end
    @(negedge sys_clk_i);
    check(timer_wrap_irq_o, 1'b1);
    check(stamp_timer_o, 16'h0000);
    @(negedge sys_clk_i);
    check(timer_wrap_irq_o, 1'b0);
    $display("test wrap done");
  endtask : t_wrap

  // Main sequence
  initial begin
    repeat (2) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    t_page();
    t_cfg();
    t_timer();
    t_tx();
    t_buf();
    t_wrap();
    tally_and_finish();
  end
endmodule : can_mailbox_paging_buffer_tb
